// File: charge_pump_mode_and_pulse_dimming_tb.sv
`timescale 1ns/1ps
// Self-checking bench for the gain selection and pulse dimming control.
module charge_pump_mode_and_pulse_dimming_tb;
    import cpd_pkg::*;
    localparam int US = 125; // Clock cycles in one microsecond.
    logic clk; // Core clock.
    logic nrst; // Reset, active low.
    logic [5:0] sink_low; // Sink comparator outputs.
    logic below; // Pump output below supply.
    wire main_ctl; // Main group pin from the host.
    wire sub_ctl; // Sub group pin from the host.
    cpd_gain_t gain; // Selected gain.
    logic pump_on; // Pump active.
    logic [5:0] sink_en; // Sink enables.
    logic [6:0] main_pct; // Main brightness.
    logic [6:0] sub_pct; // Sub brightness.
    int fails; // Mismatch count.
    int n_compared; // Comparison count.
    int cycles; // Cycles since start, for the hang limit.

    // Small counts keep the run short; expectations below follow them.
    cpd_ctrl #(.OFF_TICKS(8), .DWELL_TICKS(16), .RETRY_TICKS(64)) i_cpd_ctrl (.clk(clk), .nrst(nrst),
        .main_group_ctl(main_ctl), .sub_group_ctl(sub_ctl), .led_sink_low(sink_low),
        .pump_output_below_supply(below), .gain_q(gain), .pump_on_q(pump_on), .sink_en_q(sink_en),
        .main_pct_q(main_pct), .sub_pct_q(sub_pct));
    cpd_host_model i_cpd_host_model (.clk(clk), .main_group_ctl(main_ctl), .sub_group_ctl(sub_ctl));

    // Free-running clock of 8 ns.
    always #4 clk = ~clk;

    // Compares one result and counts it.
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Waits a bounded number of cycles for a gain, then compares.
    task automatic wait_gain(input cpd_gain_t exp, input int max_cyc, input string what);
        int n;
        n = 0;
        while (gain !== exp && n < max_cyc)
        begin
            @(posedge clk);
            n++;
        end
        // Read at the edge, before it updates, so the next drive stays on the edge.
        check(8'(gain), 8'(exp), what);
    endtask

    // Brightness expected after k steps; computed here, independent of the design.
    function automatic logic [7:0] exp_pct(input int k);
        if (k < 10)
            return 8'(100 - 10 * k);
        return (k == 10) ? 8'h05 : 8'h64;
    endfunction

    // Prints the counts and the verdict, then stops.
    task automatic finish_test;
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Main group walks through every level and wraps to full.
    task automatic t_dim_main;
        i_cpd_host_model.wake(1'b0);
        check(8'(main_pct), 8'h64, "main full on enable");
        check(8'(sink_en), 8'h0F, "main sinks only");
        check(8'(pump_on), 8'h01, "pump on");
        for (int k = 1; k <= 11; k++)
        begin
            i_cpd_host_model.pulse(1'b0, 2 * US, 2 * US);
            check(8'(main_pct), exp_pct(k), "main step");
        end
    endtask

    // Glitch ignored, long low short of the delay is a step, full delay is off.
    task automatic t_widths;
        i_cpd_host_model.pulse(1'b0, 20, 2 * US);
        check(8'(main_pct), 8'h64, "glitch ignored");
        i_cpd_host_model.pulse(1'b0, 5 * US, 2 * US);
        check(8'(main_pct), 8'h5A, "long step counts");
        i_cpd_host_model.set_pin(1'b0, 1'b0);
        repeat (12 * US) @(posedge clk);
        check(8'(main_pct), 8'h00, "main off");
        check(8'(sink_en), 8'h00, "sinks off");
        check(8'(pump_on), 8'h00, "full shutdown");
        i_cpd_host_model.wake(1'b0);
        check(8'(main_pct), 8'h64, "restart at full");
    endtask

    // Low sinks of a disabled group must not ask for more gain.
    task automatic t_mask;
        sink_low <= 6'h30;
        repeat (20) @(posedge clk);
        check(8'(gain), 8'(GAIN_1X), "disabled sub sinks ignored");
        check(8'(sink_en), 8'h0F, "sub sinks stay off");
        sink_low <= 6'h00;
        repeat (4) @(posedge clk);
    endtask

    // Sub group steps without touching the main group.
    task automatic t_sub;
        i_cpd_host_model.wake(1'b1);
        i_cpd_host_model.pulse(1'b1, 2 * US, 2 * US);
        check(8'(sub_pct), 8'h5A, "sub step");
        check(8'(main_pct), 8'h64, "main untouched");
        check(8'(sink_en), 8'h3F, "all sinks");
    endtask

    // Gain walk: 1.5x dwell, periodic and disable drops, then back to unity.
    task automatic t_gain;
        wait_gain(GAIN_1X, 0, "unity while sinks high");
        sink_low <= 6'h2E;
        wait_gain(GAIN_15X, 10, "step to 1.5x");
        repeat (12 * US) @(posedge clk);
        check(8'(gain), 8'(GAIN_15X), "still dwelling");
        wait_gain(GAIN_2X, 8 * US, "reach 2x");
        wait_gain(GAIN_15X, 66 * US, "periodic drop");
        wait_gain(GAIN_2X, 18 * US, "re-enter 2x");
        i_cpd_host_model.set_pin(1'b0, 1'b0);
        wait_gain(GAIN_15X, 11 * US, "drop on disable");
        sink_low <= 6'h00;
        below <= 1'b1;
        wait_gain(GAIN_1X, 140 * US, "retry unity");
        repeat (100) @(posedge clk);
        check(8'(gain), 8'(GAIN_1X), "unity holds");
        i_cpd_host_model.set_pin(1'b1, 1'b0);
        repeat (12 * US) @(posedge clk);
        check(8'(pump_on), 8'h00, "both off");
    endtask

    // Hang limit well above the expected run length.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 99000)
        begin
            fails++;
            $display("mismatch at %0t: run exceeded its cycle limit", $time);
            finish_test();
        end
    end

    // Reset for four cycles, then the scenarios in order.
    initial
    begin
        clk = 1'b0;
        nrst = 1'b0;
        sink_low = 6'h00;
        below = 1'b0;
        fails = 0;
        n_compared = 0;
        cycles = 0;
        repeat (3) @(posedge clk);
        #1;
        check(8'(gain), 8'(GAIN_1X), "gain in reset");
        check(8'(sink_en), 8'h00, "sinks in reset");
        @(posedge clk);
        nrst <= 1'b1;
        t_dim_main();
        t_widths();
        t_mask();
        t_sub();
        t_gain();
        finish_test();
    end
endmodule // charge_pump_mode_and_pulse_dimming_tb

// File: cpd_ctrl.sv
`timescale 1ns/1ps
module cpd_ctrl
    import cpd_pkg::*;
#(
    parameter int OFF_TICKS = OFF_DETECT_US * OSC_MHZ, // Off detect delay in ticks.
    parameter int DWELL_TICKS = MID_DWELL_US * OSC_MHZ, // 1.5x dwell before 2x, in ticks.
    parameter int RETRY_TICKS = RETRY_US * OSC_MHZ // Retry interval, in ticks.
)
(
    input wire logic clk, // Core clock, 125 MHz.
    input wire logic nrst, // Asynchronous reset, active low.
    input wire logic main_group_ctl, // Main group control pin.
    input wire logic sub_group_ctl, // Sub group control pin.
    input wire logic [5:0] led_sink_low, // Sink below the gain step threshold, one per sink.
    input wire logic pump_output_below_supply, // Pump output is below the supply input.
    output cpd_pkg::cpd_gain_t gain_q, // Selected pump gain.
    output logic pump_on_q, // Pump active; low in full shutdown.
    output logic [5:0] sink_en_q, // Sink enables.
    output logic [6:0] main_pct_q, // Main group brightness in percent.
    output logic [6:0] sub_pct_q // Sub group brightness in percent.
);
    import cpd_pkg::*;

    cpd_grp_if main_if (); // Decoded main group.
    cpd_grp_if sub_if (); // Decoded sub group.

    logic [6:0] tick_cnt_q; // Divider for the oscillator tick.
    logic tick_q; // One-cycle tick every microsecond.
    logic [5:0] low_s1_q; // First stage of the comparator synchroniser.
    logic [5:0] low_s2_q; // Synchronised comparator flags.
    logic below_s1_q; // First stage of the supply comparison synchroniser.
    logic below_s2_q; // Synchronised supply comparison.
    logic [TCNT_W-1:0] st_cnt_q; // Ticks spent in the present gain state.
    logic [5:0] grp_mask; // Sinks belonging to enabled groups.
    logic any_low; // An enabled sink is below threshold.
    logic awake; // At least one group is enabled.
    logic gain_chg; // Gain state changes at the next edge.
    cpd_gain_t gain_d; // Next gain state.

    assign main_if.tick = tick_q;
    assign sub_if.tick = tick_q;

    // One decoder per control pin.
    cpd_pulse_dec #(.OFF_TICKS(OFF_TICKS)) u_main_dec
    (
        .clk(clk),
        .nrst(nrst),
        .pin(main_group_ctl),
        .grp(main_if)
    );

    cpd_pulse_dec #(.OFF_TICKS(OFF_TICKS)) u_sub_dec
    (
        .clk(clk),
        .nrst(nrst),
        .pin(sub_group_ctl),
        .grp(sub_if)
    );

    // The core clock is divided down to stand in for the 1 MHz oscillator.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            tick_cnt_q <= '0;
            tick_q <= 1'b0;
        end
        else
        begin
            tick_q <= (tick_cnt_q == 7'(TICK_CYC - 1));
            tick_cnt_q <= (tick_cnt_q == 7'(TICK_CYC - 1)) ? '0 : tick_cnt_q + 1'b1;
        end
    end

    // Comparators are analog outputs, asynchronous to the core clock.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            low_s1_q <= '0;
            low_s2_q <= '0;
            below_s1_q <= 1'b0;
            below_s2_q <= 1'b0;
        end
        else
        begin
            low_s1_q <= led_sink_low;
            low_s2_q <= low_s1_q;
            below_s1_q <= pump_output_below_supply;
            below_s2_q <= below_s1_q;
        end
    end

    // Sinks of a disabled group do not ask for more gain.
    assign grp_mask = {sub_if.en, sub_if.en, {4{main_if.en}}};
    assign any_low = |(low_s2_q & grp_mask);
    assign awake = main_if.en | sub_if.en;

    // Next gain state.
    always_comb
    begin
        gain_d = gain_q;
        if (!awake)
        begin
            // Both groups off is a full shutdown; restart from unity.
            gain_d = GAIN_1X;
        end
        else
        begin
            unique case (gain_q)
                GAIN_1X:
                begin
                    if (any_low)
                    begin
                        gain_d = GAIN_15X;
                    end
                end
                GAIN_15X:
                begin
                    if (any_low && st_cnt_q >= TCNT_W'(DWELL_TICKS))
                    begin
                        gain_d = GAIN_2X;
                    end
                    else if (below_s2_q && st_cnt_q >= TCNT_W'(RETRY_TICKS))
                    begin
                        gain_d = GAIN_1X;
                    end
                end
                GAIN_2X:
                begin
                    // Periodic or disable-driven fallback; 2x returns after the dwell if needed.
                    if (st_cnt_q >= TCNT_W'(RETRY_TICKS) || main_if.off_evt || sub_if.off_evt)
                    begin
                        gain_d = GAIN_15X;
                    end
                end
            endcase
        end
    end

    assign gain_chg = (gain_d != gain_q);

    // Gain state register.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            gain_q <= GAIN_1X;
        end
        else
        begin
            gain_q <= gain_d;
        end
    end

    // Dwell and retry timer; it restarts on every change of gain.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_cnt_q <= '0;
        end
        else if (gain_chg)
        begin
            st_cnt_q <= '0;
        end
        else if (tick_q && st_cnt_q < TCNT_W'(RETRY_TICKS))
        begin
            st_cnt_q <= st_cnt_q + 1'b1;
        end
    end

    // Registered outputs; the percent values follow the decoded index.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pump_on_q <= 1'b0;
            sink_en_q <= '0;
            main_pct_q <= '0;
            sub_pct_q <= '0;
        end
        else
        begin
            pump_on_q <= awake;
            sink_en_q <= grp_mask;
            main_pct_q <= main_if.en ? cpd_pct(main_if.level) : 7'h00;
            sub_pct_q <= sub_if.en ? cpd_pct(sub_if.level) : 7'h00;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_unity_hold: assert property (gain_q == GAIN_1X && awake && !any_low |=> gain_q == GAIN_1X)
        else $error("unity gain left without a low sink");
    a_unity_leave: assert property (gain_q == GAIN_1X && awake && any_low |=> gain_q == GAIN_15X)
        else $error("low sink did not raise gain to 1.5x");
    a_no_skip: assert property (gain_q == GAIN_2X |-> $past(gain_q) != GAIN_1X)
        else $error("gain jumped from unity to double");
    a_dwell_min: assert property (gain_q == GAIN_15X && awake
        && st_cnt_q < TCNT_W'(DWELL_TICKS) |=> gain_q != GAIN_2X)
        else $error("double gain entered before the dwell");
    a_retry_unity: assert property (gain_q == GAIN_15X && awake && !any_low && below_s2_q
        && st_cnt_q >= TCNT_W'(RETRY_TICKS) |=> gain_q == GAIN_1X)
        else $error("1.5x retry to unity missed");
    a_drop_double: assert property (gain_q == GAIN_2X && awake
        && (main_if.off_evt || sub_if.off_evt) |=> gain_q == GAIN_15X)
        else $error("disable in double gain did not drop to 1.5x");
    // A group may wake one cycle later, so only the cycle right after the shutdown is judged.
    a_full_shutdown: assert property (!awake |=> gain_q == GAIN_1X && !pump_on_q && sink_en_q == 6'h00)
        else $error("both groups off did not shut down");
    a_sink_map: assert property (##1 sink_en_q == $past(grp_mask))
        else $error("sink enables do not follow the groups");
    c_enter_mid: cover property (gain_q == GAIN_1X ##1 gain_q == GAIN_15X);
    c_enter_double: cover property (gain_q == GAIN_15X ##1 gain_q == GAIN_2X);
    c_retry_unity: cover property (gain_q == GAIN_15X ##1 gain_q == GAIN_1X);
endmodule // cpd_ctrl

// File: cpd_grp_if.sv
`timescale 1ns/1ps
// State of one LED group as decoded from its control pin.
interface cpd_grp_if;
    logic tick; // One-cycle oscillator tick from the controller.
    logic en; // Group is enabled.
    logic [3:0] level; // Brightness index.
    logic off_evt; // One-cycle pulse when the group is switched off.

    modport dec (input tick, output en, output level, output off_evt);
    modport ctl (output tick, input en, input level, input off_evt);
endinterface

// File: cpd_host_model.sv
`timescale 1ns/1ps
// Host side of the two group control pins, driving timed low pulses.
module cpd_host_model
(
    input wire logic clk, // Core clock.
    output logic main_group_ctl, // Main group control pin.
    output logic sub_group_ctl // Sub group control pin.
);
    // Both pins start low, which is the shutdown level.
    initial
    begin
        main_group_ctl = 1'b0;
        sub_group_ctl = 1'b0;
    end

    // Sets one pin just after a clock edge; sel high picks the sub group.
    task automatic set_pin(input logic sel, input logic v);
        @(posedge clk);
        if (sel)
            sub_group_ctl <= v;
        else
            main_group_ctl <= v;
    endtask

    // One step pulse: low for low_cyc plus one cycles, then high for high_cyc cycles before returning.
    task automatic pulse(input logic sel, input int low_cyc, input int high_cyc);
        set_pin(sel, 1'b0);
        repeat (low_cyc) @(posedge clk);
        set_pin(sel, 1'b1);
        repeat (high_cyc) @(posedge clk);
    endtask

    // Raises a pin from shutdown and keeps the first high long enough.
    task automatic wake(input logic sel);
        set_pin(sel, 1'b1);
        repeat (51 * 125) @(posedge clk);
    endtask
endmodule // cpd_host_model

// File: cpd_pkg.sv
package cpd_pkg;

    // Core clock and the internal oscillator that times the off detect, dwell and retry intervals; the step low minimum is in core cycles.
    localparam int CLK_MHZ = 125;
    localparam int OSC_MHZ = 1;
    localparam int TICK_CYC = CLK_MHZ / OSC_MHZ;

    // Least low time of a step pulse, in ns, and its cycle count rounded up.
    localparam int STEP_LOW_MIN_NS = 500;
    localparam int STEP_LOW_MIN_CYC = (STEP_LOW_MIN_NS * CLK_MHZ + 999) / 1000;

    // Intervals in microseconds; one oscillator tick is one microsecond.
    localparam int OFF_DETECT_US = 500;
    localparam int MID_DWELL_US = 1000;
    localparam int RETRY_US = 130000;

    // Widths of the tick counters and of the brightness index.
    localparam int TCNT_W = 18;
    localparam int LVL_W = 4;

    // Brightness index: 0 is full current, the last index is the lowest step.
    localparam logic [3:0] LEVEL_FULL = 4'h0;
    localparam logic [3:0] LEVEL_LAST = 4'hA;

    // Pump gain states.
    typedef enum logic [1:0] {GAIN_1X, GAIN_15X, GAIN_2X} cpd_gain_t;

    // Brightness in percent for a given index.
    function automatic logic [6:0] cpd_pct(input logic [3:0] lvl);
        logic [6:0] pct;
        pct = 7'h05;
        if (lvl < LEVEL_LAST)
        begin
            // Widen the index first so the product cannot wrap at four bits.
            pct = 7'h64 - 7'(lvl) * 7'h0A;
        end
        return pct;
    endfunction

endpackage

// File: cpd_pulse_dec.sv
`timescale 1ns/1ps
// Decodes one single-wire group control pin into enable and brightness.
module cpd_pulse_dec
    import cpd_pkg::*;
#(
    parameter int OFF_TICKS = OFF_DETECT_US * OSC_MHZ
)
(
    input wire logic clk, // Core clock.
    input wire logic nrst, // Asynchronous reset, active low.
    input wire logic pin, // Raw group control pin.
    cpd_grp_if.dec grp // Decoded group state.
);
    logic pin_s1_q; // First synchroniser stage.
    logic pin_s2_q; // Second synchroniser stage.
    logic pin_q; // Previous synchronised level.
    logic [TCNT_W-1:0] lo_ticks_q; // Ticks spent low since the last fall.
    logic [7:0] lo_cyc_q; // Cycles spent low, saturating at the step minimum.
    logic en_q; // Group enable.
    logic [3:0] level_q; // Brightness index.
    logic off_q; // Switch-off pulse.
    logic fall;
    logic rise;
    logic off_hit;

    assign fall = pin_q & ~pin_s2_q;
    assign rise = ~pin_q & pin_s2_q;
    assign off_hit = ~pin_s2_q & en_q & (lo_ticks_q == TCNT_W'(OFF_TICKS));
    assign grp.en = en_q;
    assign grp.level = level_q;
    assign grp.off_evt = off_q;

    // The pin is asynchronous, so two stages pass it before any logic reads it.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
            pin_q <= 1'b0;
        end
        else
        begin
            pin_s1_q <= pin;
            pin_s2_q <= pin_s1_q;
            pin_q <= pin_s2_q;
        end
    end

    // Low time is measured in oscillator ticks and in core cycles for glitches.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            lo_ticks_q <= '0;
            lo_cyc_q <= '0;
        end
        else if (fall)
        begin
            lo_ticks_q <= '0;
            lo_cyc_q <= '0;
        end
        else if (!pin_s2_q)
        begin
            if (grp.tick && lo_ticks_q <= TCNT_W'(OFF_TICKS))
            begin
                lo_ticks_q <= lo_ticks_q + 1'b1;
            end
            if (lo_cyc_q < 8'(STEP_LOW_MIN_CYC))
            begin
                lo_cyc_q <= lo_cyc_q + 1'b1;
            end
        end
    end

    // Enable and brightness; a long low switches the group off and resets dimming.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            en_q <= 1'b0;
            level_q <= LEVEL_FULL;
            off_q <= 1'b0;
        end
        else
        begin
            off_q <= off_hit;
            if (off_hit)
            begin
                // A long low is a shutdown request, never a step.
                en_q <= 1'b0;
                level_q <= LEVEL_FULL;
            end
            else if (rise && !en_q)
            begin
                // First rise after an off period enables at full current.
                en_q <= 1'b1;
                level_q <= LEVEL_FULL;
            end
            else if (rise && lo_cyc_q >= 8'(STEP_LOW_MIN_CYC) && lo_ticks_q < TCNT_W'(OFF_TICKS))
            begin
                // Lows shorter than the step minimum are dropped as glitches.
                level_q <= (level_q == LEVEL_LAST) ? LEVEL_FULL : level_q + 1'b1;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_first_rise_full: assert property (rise && !en_q && !off_hit |=> en_q && level_q == LEVEL_FULL)
        else $error("first rise did not enable at full current");
    a_step_wraps_full: assert property (rise && en_q && level_q == LEVEL_LAST
        && lo_cyc_q >= 8'(STEP_LOW_MIN_CYC) && lo_ticks_q < TCNT_W'(OFF_TICKS) |=> level_q == LEVEL_FULL)
        else $error("step past lowest level did not restore full");
    a_long_low_off: assert property (off_hit |=> !en_q && off_q ##1 !off_q)
        else $error("long low did not switch the group off");
    a_short_glitch: assert property (rise && en_q && lo_cyc_q < 8'(STEP_LOW_MIN_CYC) |=> $stable(level_q))
        else $error("glitch changed brightness");
    c_step_taken: cover property (rise && en_q && lo_cyc_q >= 8'(STEP_LOW_MIN_CYC));
    c_group_off: cover property (off_q);
endmodule // cpd_pulse_dec
